// ---- fmsr_feedback_regs.sv ----
// Behaviour
// - Power-on outcome readable: 0 failed, 1 succeeded.
// - Calibration status readable: 0 running, 1 done.
// - Capacitor wear warning mask readable; zero means none.
// - Relay detection status mask readable; zero means clear.
// - Relay one detection enable mask readable.
// - Relay two detection enable mask readable.
// - Access level code readable: user, tech, factory.
// - Setting store state readable; 12 means loaded.
// - Operating state code readable, values 0 to 4.
// - Node id mirrored, default 10, range 0-255.
// - Bit rate mirrored as rate over ten.
`timescale 1ns/1ns
`default_nettype none

module fmsr_feedback_regs
  import fmsr_pkg::*;
(
  input wire logic clock_in,
  input wire logic srst_in,
  input wire fmsr_status_s status_in,
  input wire fmsr_req_s req_in,
  output fmsr_rsp_s rsp_out,
  output logic write_ignored_out,
  output logic params_loaded_out,
  output logic detections_running_out
);

  // =====================================================================
  // Helpers
  // =====================================================================
  // Widen a single flag to a register word
  function automatic fmsr_word_t flag_word(input logic flag);
    flag_word = {15'h0000, flag};
  endfunction

  // Only the three documented bit rate codes are accepted
  function automatic logic bit_rate_legal(input fmsr_word_t code);
    bit_rate_legal = (code == FMSR_BIT_RATE_9600) ||
                     (code == FMSR_BIT_RATE_38400) ||
                     (code == FMSR_BIT_RATE_115200);
  endfunction

  // Access level code 3 is unused and never reaches the shadow
  function automatic logic access_legal(input logic [1:0] code);
    access_legal = (code != 2'b11);
  endfunction

  // Setting store states run from zero up to the top state only
  function automatic logic store_state_legal(input logic [4:0] code);
    store_state_legal = (code <= FMSR_SETTING_STORE_FSM_STATE_MAX);
  endfunction

  // Operating states end at run-detections
  function automatic logic board_operating_state_legal(input logic [2:0] code);
    board_operating_state_legal = (code <= FMSR_SYS_RUN_DETECT);
  endfunction

  // =====================================================================
  // Shadow registers
  // =====================================================================
  // Single-bit outcome shadows
  logic power_on_result_q;
  logic initial_calibration_done_q;

  // Detection masks
  fmsr_word_t capacitor_wear_warning_mask_q;
  fmsr_word_t active_detection_mask_q;
  fmsr_word_t relay_one_detect_enables_q;
  fmsr_word_t relay_two_detect_enables_q;

  // Capture flag and coded states
  logic waveform_capture_busy_q;
  fmsr_access_e privilege_level_q;
  logic [4:0] setting_store_fsm_state_q;
  fmsr_board_operating_state_e board_operating_state_q;

  // Measurement and serial mirrors
  fmsr_word_t nominal_line_voltage_q;
  logic [7:0] serial_node_id_mirror_q;
  fmsr_word_t serial_bit_rate_mirror_q;

  // Answer path and summaries
  fmsr_rsp_s rsp_q;
  fmsr_rsp_s rsp_d;
  logic write_ignored_q;
  logic params_loaded_q;
  logic detections_running_q;
  logic wr_take;
  logic rd_take;
  logic params_loaded_d;
  logic detections_running_d;

  // =====================================================================
  // Request qualification
  // =====================================================================
  // A write wins over a read in the same cycle
  assign wr_take = req_in.wr;
  assign rd_take = req_in.rd && !req_in.wr;

  // =====================================================================
  // Status shadows
  // =====================================================================
  // Power-on outcome flag
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      power_on_result_q <= 1'b0;
    end else begin
      power_on_result_q <= status_in.power_on_ok;
    end
  end

  // Initial calibration flag
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      initial_calibration_done_q <= 1'b0;
    end else begin
      initial_calibration_done_q <= status_in.calibration_done;
    end
  end

  // Waveform capture flag, carried without a rule of its own
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      waveform_capture_busy_q <= 1'b0;
    end else begin
      waveform_capture_busy_q <= status_in.capture_busy;
    end
  end

  // Capacitor wear warnings, one bit per detection
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      capacitor_wear_warning_mask_q <= FMSR_RST_WORD;
    end else begin
      capacitor_wear_warning_mask_q <= status_in.capacitor_wear_warning;
    end
  end

  // Relay detection status, one bit per detection
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      active_detection_mask_q <= FMSR_RST_WORD;
    end else begin
      active_detection_mask_q <= status_in.detection_active;
    end
  end

  // Relay one detection enables
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      relay_one_detect_enables_q <= FMSR_RST_WORD;
    end else begin
      relay_one_detect_enables_q <= status_in.relay_one_enables;
    end
  end

  // Relay two detection enables
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      relay_two_detect_enables_q <= FMSR_RST_WORD;
    end else begin
      relay_two_detect_enables_q <= status_in.relay_two_enables;
    end
  end

  // =====================================================================
  // Coded states
  // =====================================================================
  // Access level; the unused code holds the last legal level
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      privilege_level_q <= FMSR_ACCESS_USER;
    end else if (access_legal(status_in.privilege_level)) begin
      privilege_level_q <= fmsr_access_e'(status_in.privilege_level);
    end
  end

  // Setting store state; codes above the top state are held off
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      setting_store_fsm_state_q <= 5'h00;
    end else if (store_state_legal(status_in.setting_store_state)) begin
      setting_store_fsm_state_q <= status_in.setting_store_state;
    end
  end

  // Operating state; codes above run-detections are held off
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      board_operating_state_q <= FMSR_SYS_INITIAL;
    end else if (board_operating_state_legal(status_in.operating_state)) begin
      board_operating_state_q <= fmsr_board_operating_state_e'(status_in.operating_state);
    end
  end

  // =====================================================================
  // Measurement and serial mirrors
  // =====================================================================
  // Rated voltage as supplied by the board
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      nominal_line_voltage_q <= FMSR_RST_WORD;
    end else begin
      nominal_line_voltage_q <= status_in.nominal_line_voltage;
    end
  end

  // Node id follows its setpoint only, never a bus write; any 8-bit value is legal
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      serial_node_id_mirror_q <= FMSR_RST_NODE_ID;
    end else begin
      serial_node_id_mirror_q <= status_in.node_id_setpoint;
    end
  end

  // Bit rate follows its setpoint; an unknown code keeps the last rate
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      serial_bit_rate_mirror_q <= FMSR_RST_BIT_RATE;
    end else if (bit_rate_legal(status_in.bit_rate_setpoint)) begin
      serial_bit_rate_mirror_q <= status_in.bit_rate_setpoint;
    end
  end

  // =====================================================================
  // Read decode
  // =====================================================================
  // Writes are refused; reads of unmapped offsets answer an error
  always_comb begin
    rsp_d = '{valid: 1'b0, err: 1'b0, data: FMSR_RST_WORD};
    if (wr_take) begin
      rsp_d.valid = 1'b1;
      rsp_d.err = 1'b1;
    end else if (rd_take) begin
      rsp_d.valid = 1'b1;
      unique case (req_in.addr)
        FMSR_OFS_POWER_ON_RESULT: begin
          rsp_d.data = flag_word(power_on_result_q);
        end
        FMSR_OFS_INITIAL_CALIBRATION_DONE: begin
          rsp_d.data = flag_word(initial_calibration_done_q);
        end
        FMSR_OFS_CAPACITOR_WEAR_WARNING_MASK: begin
          rsp_d.data = capacitor_wear_warning_mask_q;
        end
        FMSR_OFS_ACTIVE_DETECTION_MASK: begin
          rsp_d.data = active_detection_mask_q;
        end
        FMSR_OFS_RELAY_ONE_DETECT_ENABLES: begin
          rsp_d.data = relay_one_detect_enables_q;
        end
        FMSR_OFS_RELAY_TWO_DETECT_ENABLES: begin
          rsp_d.data = relay_two_detect_enables_q;
        end
        FMSR_OFS_WAVEFORM_CAPTURE_BUSY: begin
          rsp_d.data = flag_word(waveform_capture_busy_q);
        end
        FMSR_OFS_PRIVILEGE_LEVEL: begin
          rsp_d.data = {14'h0000, privilege_level_q};
        end
        FMSR_OFS_SETTING_STORE_FSM_STATE: begin
          rsp_d.data = {11'h000, setting_store_fsm_state_q};
        end
        FMSR_OFS_BOARD_OPERATING_STATE: begin
          rsp_d.data = {13'h0000, board_operating_state_q};
        end
        FMSR_OFS_NOMINAL_LINE_VOLTAGE: begin
          rsp_d.data = nominal_line_voltage_q;
        end
        FMSR_OFS_SERIAL_NODE_ID_MIRROR: begin
          rsp_d.data = {8'h00, serial_node_id_mirror_q};
        end
        FMSR_OFS_SERIAL_BIT_RATE_MIRROR: begin
          rsp_d.data = serial_bit_rate_mirror_q;
        end
        default: begin
          rsp_d.err = 1'b1;
        end
      endcase
    end
  end

  // =====================================================================
  // Answer register
  // =====================================================================
  // Registered answer, one cycle after the request
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      rsp_q <= '{valid: 1'b0, err: 1'b0, data: FMSR_RST_WORD};
    end else begin
      rsp_q <= rsp_d;
    end
  end

  // =====================================================================
  // Refused writes
  // =====================================================================
  // Pulse for every refused write; no stored value moves
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      write_ignored_q <= 1'b0;
    end else begin
      write_ignored_q <= wr_take;
    end
  end

  // =====================================================================
  // Summary levels
  // =====================================================================
  // Decoded from the shadows ahead of the output flops
  assign params_loaded_d = (setting_store_fsm_state_q == FMSR_SETTING_STORE_FSM_STATE_LOADED);
  assign detections_running_d = (board_operating_state_q == FMSR_SYS_RUN_DETECT);

  // Parameters loaded level for the board
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      params_loaded_q <= 1'b0;
    end else begin
      params_loaded_q <= params_loaded_d;
    end
  end

  // Detections running level for the board
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      detections_running_q <= 1'b0;
    end else begin
      detections_running_q <= detections_running_d;
    end
  end

  // =====================================================================
  // Outputs
  // =====================================================================
  // Register answer
  assign rsp_out = rsp_q;

  // Refused-write pulse and summary levels
  assign write_ignored_out = write_ignored_q;
  assign params_loaded_out = params_loaded_q;
  assign detections_running_out = detections_running_q;

endmodule // fmsr_feedback_regs

`default_nettype wire

// ---- fmsr_pkg.sv ----
// =====================================================================
// Feedback register bank: shared constants and carriers
// =====================================================================
package fmsr_pkg;

  // Register word and address types
  typedef logic [15:0] fmsr_word_t;
  typedef logic [15:0] fmsr_addr_t;

  // =====================================================================
  // Register offsets
  // =====================================================================
  localparam fmsr_addr_t FMSR_OFS_POWER_ON_RESULT = 16'h00c9;
  localparam fmsr_addr_t FMSR_OFS_INITIAL_CALIBRATION_DONE = 16'h00ca;
  localparam fmsr_addr_t FMSR_OFS_CAPACITOR_WEAR_WARNING_MASK = 16'h00cd;
  localparam fmsr_addr_t FMSR_OFS_ACTIVE_DETECTION_MASK = 16'h00d2;
  localparam fmsr_addr_t FMSR_OFS_RELAY_ONE_DETECT_ENABLES = 16'h00e6;
  localparam fmsr_addr_t FMSR_OFS_RELAY_TWO_DETECT_ENABLES = 16'h00f0;
  localparam fmsr_addr_t FMSR_OFS_WAVEFORM_CAPTURE_BUSY = 16'h00fb;
  localparam fmsr_addr_t FMSR_OFS_PRIVILEGE_LEVEL = 16'h00fe;
  localparam fmsr_addr_t FMSR_OFS_SETTING_STORE_FSM_STATE = 16'h00ff;
  localparam fmsr_addr_t FMSR_OFS_BOARD_OPERATING_STATE = 16'h0100;
  localparam fmsr_addr_t FMSR_OFS_NOMINAL_LINE_VOLTAGE = 16'h0104;
  localparam fmsr_addr_t FMSR_OFS_SERIAL_NODE_ID_MIRROR = 16'h012c;
  localparam fmsr_addr_t FMSR_OFS_SERIAL_BIT_RATE_MIRROR = 16'h012d;

  // =====================================================================
  // Reset values and codes
  // =====================================================================
  localparam fmsr_word_t FMSR_RST_WORD = 16'h0000;
  localparam logic [7:0] FMSR_RST_NODE_ID = 8'h0a;
  localparam fmsr_word_t FMSR_BIT_RATE_9600 = 16'h03c0;
  localparam fmsr_word_t FMSR_BIT_RATE_38400 = 16'h0f00;
  localparam fmsr_word_t FMSR_BIT_RATE_115200 = 16'h2d00;
  localparam fmsr_word_t FMSR_RST_BIT_RATE = FMSR_BIT_RATE_38400;
  localparam logic [4:0] FMSR_SETTING_STORE_FSM_STATE_LOADED = 5'h0c;
  localparam logic [4:0] FMSR_SETTING_STORE_FSM_STATE_MAX = 5'h11;

  // Parameter access level codes
  typedef enum logic [1:0] {
    FMSR_ACCESS_USER = 2'b00,
    FMSR_ACCESS_TECH = 2'b01,
    FMSR_ACCESS_FACTORY = 2'b10
  } fmsr_access_e;

  // Board operating state codes
  typedef enum logic [2:0] {
    FMSR_SYS_INITIAL = 3'b000,
    FMSR_SYS_PARAM_LOAD = 3'b001,
    FMSR_SYS_CALIBRATING = 3'b010,
    FMSR_SYS_CALIB_CHECK = 3'b011,
    FMSR_SYS_RUN_DETECT = 3'b100
  } fmsr_board_operating_state_e;

  // =====================================================================
  // Carriers
  // =====================================================================
  // Live status from the board logic, same clock domain
  typedef struct packed {
    logic power_on_ok;
    logic calibration_done;
    fmsr_word_t capacitor_wear_warning;
    fmsr_word_t detection_active;
    fmsr_word_t relay_one_enables;
    fmsr_word_t relay_two_enables;
    logic capture_busy;
    logic [1:0] privilege_level;
    logic [4:0] setting_store_state;
    logic [2:0] operating_state;
    fmsr_word_t nominal_line_voltage;
    logic [7:0] node_id_setpoint;
    fmsr_word_t bit_rate_setpoint;
  } fmsr_status_s;

  // Register request from the serial slave front end
  typedef struct packed {
    logic rd;
    logic wr;
    fmsr_addr_t addr;
    fmsr_word_t wdata;
  } fmsr_req_s;

  // Register answer to the serial slave front end
  typedef struct packed {
    logic valid;
    logic err;
    fmsr_word_t data;
  } fmsr_rsp_s;

endpackage : fmsr_pkg

// ---- fmsr_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
// ====================
// Feedback bank checker
module fmsr_chk
  import fmsr_pkg::*;
(
  input wire logic clock_in,
  input wire logic srst_in,
  input wire fmsr_status_s status_in,
  input wire fmsr_req_s req_in,
  input wire fmsr_rsp_s rsp_out,
  input wire logic write_ignored_out,
  input wire logic params_loaded_out,
  input wire logic detections_running_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);
  // Read data lags status by two edges, so guard the edge just after reset
  answer_slot_a: assert property ((req_in.rd || req_in.wr) |=> rsp_out.valid)
    else $error("request not answered");
  idle_quiet_a: assert property (!(req_in.rd || req_in.wr) |=> !rsp_out.valid && !write_ignored_out)
    else $error("answer without request");
  write_refused_a: assert property (req_in.wr |=> rsp_out.err && rsp_out.data == 16'h0000 && write_ignored_out)
    else $error("write not refused");
  power_read_a: assert property (req_in.rd && !req_in.wr && req_in.addr == FMSR_OFS_POWER_ON_RESULT
    && !$past(srst_in) |=> !rsp_out.err && rsp_out.data == {15'h0000, $past(status_in.power_on_ok, 2)})
    else $error("power on word wrong");
  wear_read_a: assert property (req_in.rd && !req_in.wr && req_in.addr == FMSR_OFS_CAPACITOR_WEAR_WARNING_MASK
    && !$past(srst_in) |=> rsp_out.data == $past(status_in.capacitor_wear_warning, 2))
    else $error("wear mask wrong");
  level_read_a: assert property (req_in.rd && !req_in.wr && req_in.addr == FMSR_OFS_PRIVILEGE_LEVEL
    && !$past(srst_in) && $past(status_in.privilege_level) != 2'b11
    |=> rsp_out.data == {14'h0000, $past(status_in.privilege_level, 2)})
    else $error("access level wrong");
  node_read_a: assert property (req_in.rd && !req_in.wr && req_in.addr == FMSR_OFS_SERIAL_NODE_ID_MIRROR
    && !$past(srst_in) |=> rsp_out.data == {8'h00, $past(status_in.node_id_setpoint, 2)})
    else $error("node id wrong");
  loaded_flag_a: assert property (!$past(srst_in) && !$past(srst_in, 2)
    && $past(status_in.setting_store_state, 2) <= FMSR_SETTING_STORE_FSM_STATE_MAX
    |-> params_loaded_out == ($past(status_in.setting_store_state, 2) == FMSR_SETTING_STORE_FSM_STATE_LOADED))
    else $error("loaded flag wrong");
  running_flag_a: assert property (!$past(srst_in) && !$past(srst_in, 2)
    && $past(status_in.operating_state, 2) <= 3'h4
    |-> detections_running_out == ($past(status_in.operating_state, 2) == 3'h4))
    else $error("running flag wrong");
  cover property (req_in.wr ##1 write_ignored_out);
  cover property (params_loaded_out);
  cover property (detections_running_out);
endmodule // fmsr_chk
bind fmsr_feedback_regs fmsr_chk i_chk (.clock_in(clock_in), .srst_in(srst_in), .status_in(status_in),
  .req_in(req_in), .rsp_out(rsp_out), .write_ignored_out(write_ignored_out),
  .params_loaded_out(params_loaded_out), .detections_running_out(detections_running_out));
`default_nettype wire

// ---- fmsr_master.sv ----
`timescale 1ns/1ns
`default_nettype none
// ====================
// Serial master stand-in
module fmsr_master
  import fmsr_pkg::*;
(
  input wire logic clock_in,
  input wire fmsr_rsp_s rsp_in,
  output fmsr_req_s req_out
);
  initial req_out = '0;
  // One access: held over one taking edge, answer taken in the following cycle
  task automatic access(input logic wr, input fmsr_addr_t addr, output fmsr_rsp_s rsp);
    @(negedge clock_in);
    req_out = '{rd: !wr, wr: wr, addr: addr, wdata: ~addr};
    @(negedge clock_in);
    rsp = rsp_in;
    req_out = '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: addr}; // Released lines never keep the old value
  endtask
endmodule // fmsr_master
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ns
`default_nettype none
// ====================
// Feedback bank bench
module tb;
  import fmsr_pkg::*;
  logic clock_in = 1'b0;
  logic srst_in = 1'b1;
  fmsr_status_s st;
  fmsr_req_s req;
  fmsr_rsp_s rsp, r;
  logic wr_ign, loaded, running;
  int failures = 0, num_checks = 0, cycles = 0;
  fmsr_addr_t addrs[13] = '{16'h00c9, 16'h00ca, 16'h00cd, 16'h00d2, 16'h00e6, 16'h00f0, 16'h00fb,
    16'h00fe, 16'h00ff, 16'h0100, 16'h0104, 16'h012c, 16'h012d};
  fmsr_word_t rates[3] = '{16'h03c0, 16'h0f00, 16'h2d00};
  logic [4:0] stores[5] = '{5'h00, 5'h0b, 5'h0c, 5'h0d, 5'h11};
  always #5 clock_in = ~clock_in;
  // Cut a hang short
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      failures++;
      finish_test();
    end
  end
  fmsr_feedback_regs i_dut (.clock_in(clock_in), .srst_in(srst_in), .status_in(st), .req_in(req),
    .rsp_out(rsp), .write_ignored_out(wr_ign), .params_loaded_out(loaded), .detections_running_out(running));
  fmsr_master i_master (.clock_in(clock_in), .rsp_in(rsp), .req_out(req));
  task automatic check_word(input fmsr_word_t got, input fmsr_word_t exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Expected word per offset; narrow fields sit low with zero above
  function automatic fmsr_word_t expect_of(input fmsr_addr_t a);
    case (a)
      16'h00c9: return {15'h0000, st.power_on_ok};
      16'h00ca: return {15'h0000, st.calibration_done};
      16'h00cd: return st.capacitor_wear_warning;
      16'h00d2: return st.detection_active;
      16'h00e6: return st.relay_one_enables;
      16'h00f0: return st.relay_two_enables;
      16'h00fb: return {15'h0000, st.capture_busy};
      16'h00fe: return {14'h0000, st.privilege_level};
      16'h00ff: return {11'h000, st.setting_store_state};
      16'h0100: return {13'h0000, st.operating_state};
      16'h0104: return st.nominal_line_voltage;
      16'h012c: return {8'h00, st.node_id_setpoint};
      default: return st.bit_rate_setpoint;
    endcase
  endfunction
  task automatic read_all();
    for (int i = 0; i < 13; i++) begin
      i_master.access(1'b0, addrs[i], r);
      check_bit(r.err, 1'b0);
      check_word(r.data, expect_of(addrs[i]));
    end
  endtask
  // Main sequence
  initial begin
    st = '0;
    st.node_id_setpoint = 8'h0a;
    st.bit_rate_setpoint = 16'h0f00;
    repeat (5) @(negedge clock_in);
    check_bit(rsp.valid | wr_ign | loaded | running, 1'b0);
    srst_in = 1'b0;
    for (int k = 0; k < 5; k++) begin
      st = '{power_on_ok: k[0], calibration_done: !k[0], capacitor_wear_warning: 16'h0001 << k,
        detection_active: 16'h8000 >> k, relay_one_enables: 16'h5a5a + 16'(k), relay_two_enables: 16'ha5a5 - 16'(k),
        capture_busy: k[1], privilege_level: 2'(k % 3), setting_store_state: stores[k], operating_state: 3'(k),
        nominal_line_voltage: 16'h12c0 + 16'(k), node_id_setpoint: k[0] ? 8'hff : 8'h00, bit_rate_setpoint: rates[k % 3]};
      read_all();
      check_bit(loaded, k == 2);
      check_bit(running, k == 4);
    end
    foreach (addrs[i]) begin
      i_master.access(1'b1, addrs[i], r);
      check_bit(r.valid & r.err & wr_ign, 1'b1);
      check_word(r.data, 16'h0000);
    end
    read_all();
    i_master.access(1'b0, 16'h00cb, r);
    check_bit(r.err, 1'b1);
    check_word(r.data, 16'h0000);
    // Unused codes keep the last legal values
    st.privilege_level = 2'b11;
    st.setting_store_state = 5'h12;
    st.operating_state = 3'h5;
    st.bit_rate_setpoint = 16'h1234;
    i_master.access(1'b0, 16'h012d, r);
    check_word(r.data, rates[1]);
    i_master.access(1'b0, 16'h00fe, r);
    check_word(r.data, 16'h0001);
    i_master.access(1'b0, 16'h00ff, r);
    check_word(r.data, 16'h0011);
    i_master.access(1'b0, 16'h0100, r);
    check_word(r.data, 16'h0004);
    check_bit(running & !loaded, 1'b1);
    // Mid-run reset with unused codes applied: the defaults must stand
    srst_in = 1'b1;
    @(negedge clock_in);
    check_bit(rsp.valid | wr_ign | loaded | running, 1'b0);
    srst_in = 1'b0;
    i_master.access(1'b0, 16'h012d, r);
    check_word(r.data, rates[1]);
    i_master.access(1'b0, 16'h00fe, r);
    check_word(r.data, 16'h0000);
    i_master.access(1'b0, 16'h00ff, r);
    check_word(r.data, 16'h0000);
    i_master.access(1'b0, 16'h0100, r);
    check_word(r.data, 16'h0000);
    check_bit(running | loaded, 1'b0);
    finish_test();
  end
endmodule // tb
`default_nettype wire
